//--- dpsc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Reset places the controller in WAIT from any state.
// - In RUN, command 00h moves to WAIT.
// - In WAIT, command 01h or 04h..09h moves to RUN.
// - In WAIT, command 0Fh moves to SLEEP.
// - In RUN, other commands are executed and RUN is kept.
// - In WAIT, every command is accepted; settings keep WAIT.
// - In WAIT, peripheral clock runs while core clock is stopped.
// - In RUN, core clock is gated when idle (core_busy low).
// - In SLEEP only analog blocks stay powered; digital clocks stop.
// - In SLEEP the ADC is disabled while the PLL keeps running.
// - In SLEEP, power-down request moves to the powered-off state.
// - In SLEEP, wake request returns to WAIT.
// - Powered-off held while request stays high; release enters SLEEP.
// - After powered-off, SLEEP is held at least 150 us for PLL settling.
// - In powered-off state all logic and analog blocks, PLL included, are off.
module dpsc_ctrl
   import dpsc_pkg::*;
(
   input  wire logic       ref_clk,
   input  wire logic       nrst,
   input  wire logic       cmd_valid,
   input  wire logic [7:0] cmd_code,
   input  wire logic       core_busy,
   input  wire logic       power_down_request_pin,
   input  wire logic       wake_request_pin,
   output var  logic [1:0] power_state,
   output var  logic       cmd_accept,
   output var  logic       core_clk_en,
   output var  logic       periph_clk_en,
   output var  logic       pll_en,
   output var  logic       adc_en,
   output var  logic       dac_en,
   output var  logic       settle_busy
);
   localparam int CW = $clog2(SETTLE_CYC + 1);

   logic       rst_s1_q;
   logic       rst_n_q;
   logic       pdn_lvl;
   logic       wake_lvl;
   dpsc_state_t st_q;
   dpsc_state_t st_d;
   logic [CW-1:0] cnt_q;
   logic [CW-1:0] cnt_d;
   logic       acc_q;
   logic       acc_d;
   logic       core_q;
   logic       core_d;
   logic       per_q;
   logic       per_d;
   logic       pll_q;
   logic       pll_d;
   logic       adc_q;
   logic       adc_d;
   logic       dac_q;
   logic       dac_d;
   logic       busy_q;
   logic       busy_d;

   // Command starts a job in WAIT
   function automatic logic is_job(input logic [7:0] c);
      return (c == CMD_START) || (c >= CMD_JOB_LO && c <= CMD_JOB_HI);
   endfunction

   // Reset release through two flops; assertion is still immediate
   always_ff @(posedge ref_clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_s1_q <= 1'b0;
         rst_n_q  <= 1'b0;
      end
      else
      begin
         rst_s1_q <= 1'b1;
         rst_n_q  <= rst_s1_q;
      end
   end

   dpsc_sync u_pdn_sync
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n_q),
      .pin_in    (power_down_request_pin),
      .level_out (pdn_lvl)
   );

   dpsc_sync u_wake_sync
   (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n_q),
      .pin_in    (wake_request_pin),
      .level_out (wake_lvl)
   );

   // State transitions and settle counter
   always_comb
   begin
      st_d  = st_q;
      cnt_d = (cnt_q != '0) ? cnt_q - CW'(1) : cnt_q;
      acc_d = 1'b0;
      case (st_q)
         DPSC_RUN:
         begin
            acc_d = cmd_valid;
            if (cmd_valid && cmd_code == CMD_STOP)
               st_d = DPSC_WAIT;
         end
         DPSC_WAIT:
         begin
            acc_d = cmd_valid;
            if (cmd_valid && is_job(cmd_code))
               st_d = DPSC_RUN;
            else if (cmd_valid && cmd_code == CMD_SLEEP)
               st_d = DPSC_SLEEP;
         end
         DPSC_SLEEP:
         begin
            // pins honoured once PLL has settled
            if (cnt_q == '0)
            begin
               if (pdn_lvl)
                  st_d = DPSC_OFF;
               else if (wake_lvl)
                  st_d = DPSC_WAIT;
            end
         end
         DPSC_OFF:
         begin
            // leave on release, start settle time
            if (!pdn_lvl)
            begin
               st_d  = DPSC_SLEEP;
               cnt_d = CW'(SETTLE_CYC);
            end
         end
         default:
            st_d = DPSC_WAIT;
      endcase
      // pins only read in SLEEP and OFF branches above
      busy_d = (cnt_d != '0); // Registered so the settle flag leaves a flop
   end

   // Clock and power enables per next state; registered so outputs are flops
   always_comb
   begin
      core_d = 1'b0;
      per_d  = 1'b0;
      pll_d  = 1'b1;
      adc_d  = 1'b1;
      dac_d  = 1'b1;
      case (st_d)
         DPSC_RUN:
         begin
            core_d = core_busy;
            per_d  = 1'b1;
         end
         DPSC_WAIT:
            per_d = 1'b1;
         DPSC_SLEEP:
            adc_d = 1'b0;
         DPSC_OFF:
         begin
            pll_d = 1'b0;
            adc_d = 1'b0;
            dac_d = 1'b0;
         end
         default:
            per_d = 1'b1;
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         st_q   <= DPSC_WAIT;
         cnt_q  <= '0;
         acc_q  <= 1'b0;
         core_q <= 1'b0;
         per_q  <= 1'b1;
         pll_q  <= 1'b1;
         adc_q  <= 1'b1;
         dac_q  <= 1'b1;
         busy_q <= 1'b0;
      end
      else
      begin
         st_q   <= st_d;
         cnt_q  <= cnt_d;
         acc_q  <= acc_d;
         core_q <= core_d;
         per_q  <= per_d;
         pll_q  <= pll_d;
         adc_q  <= adc_d;
         dac_q  <= dac_d;
         busy_q <= busy_d;
      end
   end

   assign power_state   = st_q;
   assign cmd_accept    = acc_q;
   assign core_clk_en   = core_q;
   assign periph_clk_en = per_q;
   assign pll_en        = pll_q;
   assign adc_en        = adc_q;
   assign dac_en        = dac_q;
   assign settle_busy   = busy_q;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rst_n_q);

   sequence s_off_release;
      st_q == DPSC_OFF && !pdn_lvl;
   endsequence

   property p_stop;
      st_q == DPSC_RUN && cmd_valid && cmd_code == CMD_STOP |=> st_q == DPSC_WAIT;
   endproperty
   a_stop: assert property (p_stop) else $error("stop did not reach WAIT");

   property p_job;
      st_q == DPSC_WAIT && cmd_valid && is_job(cmd_code) |=> st_q == DPSC_RUN && per_q;
   endproperty
   a_job: assert property (p_job) else $error("job command did not reach RUN");

   property p_sleep;
      st_q == DPSC_WAIT && cmd_valid && cmd_code == CMD_SLEEP |=> st_q == DPSC_SLEEP && !adc_q;
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep command failed");

   property p_run_keep;
      st_q == DPSC_RUN && cmd_valid && cmd_code != CMD_STOP |=> st_q == DPSC_RUN && acc_q;
   endproperty
   a_run_keep: assert property (p_run_keep) else $error("RUN left on setting");

   property p_wait_clk;
      st_q == DPSC_WAIT |-> per_q && !core_q;
   endproperty
   a_wait_clk: assert property (p_wait_clk) else $error("WAIT clock gating wrong");

   property p_sleep_pwr;
      st_q == DPSC_SLEEP |-> pll_q && dac_q && !adc_q && !per_q && !core_q;
   endproperty
   a_sleep_pwr: assert property (p_sleep_pwr) else $error("SLEEP power wrong");

   property p_off_pwr;
      st_q == DPSC_OFF |-> !pll_q && !adc_q && !dac_q && !per_q;
   endproperty
   a_off_pwr: assert property (p_off_pwr) else $error("OFF power wrong");

   property p_settle;
      s_off_release |=> st_q == DPSC_SLEEP && cnt_q == CW'(SETTLE_CYC);
   endproperty
   a_settle: assert property (p_settle) else $error("settle not started");

   property p_settle_hold;
      st_q == DPSC_SLEEP && cnt_q != '0 |=> st_q == DPSC_SLEEP;
   endproperty
   a_settle_hold: assert property (p_settle_hold) else $error("left SLEEP early");

   property p_pins_ignored;
      (st_q == DPSC_RUN || st_q == DPSC_WAIT) && !cmd_valid |=> $stable(st_q);
   endproperty
   a_pins_ignored: assert property (p_pins_ignored) else $error("pin moved RUN/WAIT");

   property p_wake;
      st_q == DPSC_SLEEP && cnt_q == '0 && wake_lvl && !pdn_lvl |=> st_q == DPSC_WAIT;
   endproperty
   a_wake: assert property (p_wake) else $error("wake ignored");

   property p_pdn_off;
      st_q == DPSC_SLEEP && cnt_q == '0 && pdn_lvl |=> st_q == DPSC_OFF;
   endproperty
   a_pdn_off: assert property (p_pdn_off) else $error("power-down ignored");

   property p_off_hold;
      st_q == DPSC_OFF && pdn_lvl |=> st_q == DPSC_OFF;
   endproperty
   a_off_hold: assert property (p_off_hold) else $error("left OFF while held");

   property p_core_gate;
      st_q == DPSC_RUN |-> core_q == $past(core_busy);
   endproperty
   a_core_gate: assert property (p_core_gate) else $error("core gate wrong in RUN");
endmodule
`default_nettype wire

//--- dpsc_pkg.sv
`default_nettype none
package dpsc_pkg;

   // Power states
   typedef enum logic [1:0] {
      DPSC_RUN,
      DPSC_WAIT,
      DPSC_SLEEP,
      DPSC_OFF
   } dpsc_state_t;

   // Host command codes that steer the state
   localparam logic [7:0] CMD_STOP      = 8'h00;
   localparam logic [7:0] CMD_START     = 8'h01;
   localparam logic [7:0] CMD_JOB_LO    = 8'h04;
   localparam logic [7:0] CMD_JOB_HI    = 8'h09;
   localparam logic [7:0] CMD_SLEEP     = 8'h0F;

   // PLL settle time after leaving the powered-off state
   localparam int         SETTLE_NS     = 150000;
   localparam int         CLK_PERIOD_NS = 50;
   localparam int         SETTLE_CYC    = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int         SYNC_STAGES   = 3;

endpackage
`default_nettype wire

//--- dpsc_sync.sv
`timescale 1ns/1ps
`default_nettype none
// Three-stage pin synchroniser; output changes once stages two and three agree
module dpsc_sync
(
   input  wire logic ref_clk,
   input  wire logic rst_n,
   input  wire logic pin_in,
   output var  logic level_out
);
   logic [2:0] sh_q;
   logic [2:0] sh_d;
   logic       lvl_q;
   logic       lvl_d;

   // Next values; stage one feeds only stage two
   always_comb
   begin
      sh_d  = {sh_q[1:0], pin_in};
      lvl_d = (sh_q[1] == sh_q[2]) ? sh_q[2] : lvl_q;
   end

   // Registers
   always_ff @(posedge ref_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         sh_q  <= 3'h0;
         lvl_q <= 1'b0;
      end
      else
      begin
         sh_q  <= sh_d;
         lvl_q <= lvl_d;
      end
   end

   assign level_out = lvl_q;
endmodule
`default_nettype wire

//--- dpsc_host.sv
`timescale 1ns/1ps
`default_nettype none
// Host model: command strobes and the two power pins
module dpsc_host
(
   input  wire logic       ref_clk,
   output var  logic       cmd_valid,
   output var  logic [7:0] cmd_code,
   output var  logic       pdn_pin,
   output var  logic       wake_pin
);
   // Idle values at time zero
   initial
   begin
      cmd_valid = 1'b0;
      cmd_code  = 8'hFF;
      pdn_pin   = 1'b0;
      wake_pin  = 1'b0;
   end
   // One-cycle strobe; the code is scrambled afterwards so stale data never looks valid
   task automatic send(input logic [7:0] code);
      @(negedge ref_clk);
      cmd_valid = 1'b1;
      cmd_code  = code;
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      cmd_code  = ~code;
   endtask
   task automatic pins(input logic pdn, input logic wake);
      @(negedge ref_clk);
      pdn_pin  = pdn;
      wake_pin = wake;
   endtask
endmodule
`default_nettype wire

//--- testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench
   import dpsc_pkg::*;
;
   logic        ref_clk = 1'b0;
   logic        nrst = 1'b0;
   logic        core_busy = 1'b0;
   logic        cmd_valid, pdn, wake, cmd_accept, core_clk_en;
   logic        periph_clk_en, pll_en, adc_en, dac_en, settle_busy;
   logic [7:0]  cmd_code;
   logic [1:0]  power_state;
   int          num_errors = 0;
   int          n_tests = 0;
   dpsc_state_t exp_st;

   // 20 MHz clock
   always #25 ref_clk = ~ref_clk;

   dpsc_host i_host (.ref_clk(ref_clk), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
      .pdn_pin(pdn), .wake_pin(wake));
   dpsc_ctrl i_dpsc_ctrl (.ref_clk(ref_clk), .nrst(nrst), .cmd_valid(cmd_valid),
      .cmd_code(cmd_code), .core_busy(core_busy), .power_down_request_pin(pdn),
      .wake_request_pin(wake), .power_state(power_state), .cmd_accept(cmd_accept),
      .core_clk_en(core_clk_en), .periph_clk_en(periph_clk_en), .pll_en(pll_en),
      .adc_en(adc_en), .dac_en(dac_en), .settle_busy(settle_busy));

   task automatic end_of_test();
      if (num_errors == 0 && n_tests > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // Reference state step for one accepted command
   function automatic dpsc_state_t nxt(dpsc_state_t s, logic [7:0] c);
      if (s == DPSC_RUN && c == CMD_STOP) return DPSC_WAIT;
      if (s == DPSC_WAIT && (c == CMD_START || (c >= CMD_JOB_LO && c <= CMD_JOB_HI)))
         return DPSC_RUN;
      if (s == DPSC_WAIT && c == CMD_SLEEP) return DPSC_SLEEP;
      return s;
   endfunction

   // One cycle later, so the registered clock gate has seen core_busy
   task automatic outs();
      @(negedge ref_clk);
      check("state", power_state, exp_st);
      check("core_clk", core_clk_en, exp_st == DPSC_RUN && core_busy);
      check("periph_clk", periph_clk_en, exp_st inside {DPSC_RUN, DPSC_WAIT});
      check("adc", adc_en, exp_st inside {DPSC_RUN, DPSC_WAIT});
      check("pll", pll_en, exp_st != DPSC_OFF);
      check("dac", dac_en, exp_st != DPSC_OFF);
   endtask

   task automatic cmd(input logic [7:0] c);
      logic acc;
      acc = exp_st inside {DPSC_RUN, DPSC_WAIT};
      exp_st = nxt(exp_st, c);
      i_host.send(c);
      check("accept", cmd_accept, acc);
      check("new_state", power_state, exp_st);
      outs();
   endtask

   // Pin paths pass a synchroniser, so allow a bounded latency
   task automatic await(input dpsc_state_t s);
      int k;
      k = 0;
      exp_st = s;
      while (power_state !== s && k < 10)
      begin
         @(negedge ref_clk);
         k++;
      end
      outs();
   endtask

   initial
   begin
      int k;
      logic [7:0] c;
      void'($urandom(32'hdc6a0c9a));
      repeat (12) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      exp_st = DPSC_WAIT;
      outs();
      for (int i = 1; i <= 9; i++)
      begin
         cmd(8'(i));
         if (exp_st == DPSC_RUN)
            cmd(CMD_STOP);
      end
      repeat (200)
      begin
         c = 8'($urandom);
         core_busy = 1'($urandom);
         // no start, job or sleep command in RUN; no sleep in WAIT either
         if (exp_st == DPSC_RUN && nxt(DPSC_WAIT, c) != DPSC_WAIT)
            c = 8'h21;
         if (c == CMD_SLEEP)
            c = 8'h20;
         cmd(c);
      end
      if (exp_st == DPSC_RUN)
         cmd(CMD_STOP);
      // Pins must not move RUN or WAIT
      for (int i = 0; i < 2; i++)
      begin
         cmd(i == 0 ? CMD_START : CMD_STOP);
         i_host.pins(1'b1, 1'b1);
         repeat (8) @(negedge ref_clk);
         outs();
         i_host.pins(1'b0, 1'b0);
         repeat (8) @(negedge ref_clk);
      end
      cmd(CMD_SLEEP);
      cmd(CMD_START);
      i_host.pins(1'b1, 1'b0);
      await(DPSC_OFF);
      repeat (20) @(negedge ref_clk);
      cmd(CMD_START);
      i_host.pins(1'b0, 1'b0);
      await(DPSC_SLEEP);
      k = 0;
      while (settle_busy === 1'b1 && k < 4000)
      begin
         @(negedge ref_clk);
         k++;
      end
      check("settle_long", 1'(k >= SETTLE_CYC - 3), 1'b1);
      check("settle_end", 1'(k < 4000), 1'b1);
      check("settle_state", power_state, DPSC_SLEEP);
      i_host.pins(1'b0, 1'b1);
      await(DPSC_WAIT);
      i_host.pins(1'b0, 1'b0);
      cmd(CMD_START);
      nrst = 1'b0;
      #1;
      check("reset_state", power_state, DPSC_WAIT);
      repeat (2) @(negedge ref_clk);
      nrst = 1'b1;
      repeat (3) @(negedge ref_clk);
      exp_st = DPSC_WAIT;
      outs();
      end_of_test();
   end

   // Watchdog well beyond the expected run length
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      end_of_test();
   end
endmodule
`default_nettype wire
